// ### rtl/acs_sync_ctrl.sv
/*
 * amplified channel sync and control: register file on classic wishbone, digital input
 * disable of the analog pins, gain and switch control of the amplifier, sync source
 * selection, conversion start, auto trigger, abort and restart, result registers.
 * assumes the adc core on the same clock returns its 10-bit code on adc_result_i; pin
 * levels, pwm controller sync events and the amplifier output change flag are asynchronous.
 */
// The Wishbone register port and the placing of the registers were left to the implementer.
// Notes on behaviour
// - a set input-disable bit gates the pin buffer off and reads the pin as zero.
// - gain code 00/01/10/11 selects gain 5, 10, 20, 40.
// - the amplifier samples on each rising edge of the selected pwm sync event, or each falling edge of the divided clock for internal sync.
// - internal sync is adc clock divided by eight, sample at a fixed phase.
// - a user start takes 13 cycles with divided clock low, 14 when high.
// - sync source 00 internal, 01 first pwm sync event, 11 second event.
// - an enabled amplifier samples on every sync event, busy or not.
// - other channels are refused while an amplified conversion runs.
// - with auto trigger off, setting the start bit begins the conversion at once.
// - an amplifier change during sampling aborts, then restarts once stable.
// - auto trigger starts at the first sync event after the latest trigger.
// - auto trigger does not free-run; each conversion needs a new start bit.
// - ground select opens the negative pin and grounds the amplifier input.
// - input shunt shorts the inputs and releases the ground switch.
// - clearing enable during a conversion takes effect when it completes.
// - result high holds the top bits, result low the bottom eight bits.
// - after a low read, results freeze until the high register is read.
`timescale 1ns/1ps
`include "acs_consts.svh"

module acs_sync_ctrl
	import acs_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// analog pins, digital side
	input wire logic [2:0] pin_level_i,
	output logic [2:0] pin_value_o,
	// sync events from the pwm controllers
	input wire logic pwm_ctrl_r_sync_event_i,
	input wire logic pwm_ctrl_2_sync_event_i,
	// auto trigger events, same clock
	input wire logic [15:0] auto_trig_evt_i,
	// amplifier control
	input wire logic amp_out_change_i,
	output acs_analog_ctl_t analog_o,
	output logic amp_sample_o,
	output logic divided_sync_clock_o,
	// adc core
	input wire logic [9:0] adc_result_i,
	output acs_adc_ctl_t adc_o,
	// other channel requests
	input wire logic other_conv_req_i,
	output logic other_conv_grant_o
);

	// ****************************************
	// decoders
	// ****************************************
	function automatic logic [5:0] gain_of(input logic [1:0] code);
		case (code)
			2'h0: gain_of = `ACS_GAIN_5;
			2'h1: gain_of = `ACS_GAIN_10;
			2'h2: gain_of = `ACS_GAIN_20;
			default: gain_of = `ACS_GAIN_40;
		endcase
	endfunction

	function automatic logic sync_of(input logic [1:0] code, input logic int_evt,
		input logic [1:0] pwm_evt);
		case (acs_sync_src_t'(code))
			ACS_SYNC_INTERNAL: sync_of = int_evt;
			ACS_SYNC_PWM_R: sync_of = pwm_evt[0];
			ACS_SYNC_PWM_2: sync_of = pwm_evt[1];
			ACS_SYNC_NONE: sync_of = 1'b0;
			default: sync_of = 1'b0;
		endcase
	endfunction

	// ****************************************
	// state
	// ****************************************
	acs_state_t q_ff;
	acs_state_t nxt_q;
	logic [2:0] pin_gated;
	logic [1:0] pwm_edge;
	logic int_evt;
	logic sync_evt;
	logic bus_req;
	logic auto_en;
	logic start_req;
	logic conv_done;
	logic [7:0] wbyte;

	// a disabled pin reads zero whatever its level
	genvar gi;
	generate
		for (gi = 0; gi <= `ACS_PIN_DIS_HI; gi++) begin : g_pin
			assign pin_gated[gi] = q_ff.pin_s[gi] & ~q_ff.pin_dis[gi];
		end
	endgenerate

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		nxt_q = q_ff;
		nxt_q.sample = 1'b0;
		nxt_q.adc.start = 1'b0;
		nxt_q.adc.abort = 1'b0;
		wbyte = wb_dat_i[7:0];

		// two-stage synchronisers for everything from outside this clock
		nxt_q.pin_m = pin_level_i;
		nxt_q.pin_s = q_ff.pin_m;
		nxt_q.evt_m = {pwm_ctrl_2_sync_event_i, pwm_ctrl_r_sync_event_i};
		nxt_q.evt_s = q_ff.evt_m;
		nxt_q.evt_d = q_ff.evt_s;
		nxt_q.chg_m = amp_out_change_i;
		nxt_q.chg_s = q_ff.chg_m;
		pwm_edge = q_ff.evt_s & ~q_ff.evt_d;
		nxt_q.pin_o = pin_gated;

		// divide by eight; the falling edge of the divided clock is the internal sync
		nxt_q.div_cnt = q_ff.div_cnt + 3'h1;
		nxt_q.div_clk = nxt_q.div_cnt[2];
		int_evt = (q_ff.div_cnt == `ACS_DIV_LAST);
		sync_evt = sync_of(q_ff.amp_csr[`ACS_CSR_TS_HI:`ACS_CSR_TS_LO], int_evt, pwm_edge);

		// disable is deferred while converting
		if (!q_ff.adc.busy) begin
			nxt_q.amp_on = q_ff.amp_csr[`ACS_CSR_EN];
		end
		nxt_q.sample = q_ff.amp_on & sync_evt;

		// auto trigger: remember the latest selected trigger event
		auto_en = q_ff.conv_ctrl[`ACS_CC_AUTO];
		if (auto_en && auto_trig_evt_i[q_ff.conv_ctrl[`ACS_CC_TS_HI:`ACS_CC_TS_LO]]) begin
			nxt_q.trig_pend = 1'b1;
		end

		// conversion start and sequencing
		start_req = q_ff.conv_ctrl[`ACS_CC_START] && !q_ff.adc.busy &&
			(!auto_en || (q_ff.trig_pend && sync_evt));
		conv_done = 1'b0;
		if (start_req) begin
			nxt_q.adc.busy = 1'b1;
			nxt_q.adc.start = 1'b1;
			nxt_q.cnt = 4'h0;
			nxt_q.trig_pend = 1'b0;
			nxt_q.restart_wait = 1'b0;
			// a start in the high half waits one more cycle for the sync phase
			nxt_q.len = q_ff.div_clk ? `ACS_CONV_HIGH : `ACS_CONV_LOW;
		end else if (q_ff.adc.busy) begin
			if (q_ff.restart_wait) begin
				if (!q_ff.chg_s) begin
					nxt_q.restart_wait = 1'b0;
					nxt_q.adc.start = 1'b1;
					nxt_q.cnt = 4'h0;
				end
			end else if (q_ff.cnt < `ACS_SAMPLE_CYC && q_ff.chg_s) begin
				nxt_q.adc.abort = 1'b1;
				nxt_q.restart_wait = 1'b1;
				nxt_q.cnt = 4'h0;
			end else if (q_ff.cnt == q_ff.len - 4'h1) begin
				conv_done = 1'b1;
			end else begin
				nxt_q.cnt = q_ff.cnt + 4'h1;
			end
		end
		if (conv_done) begin
			nxt_q.adc.busy = 1'b0;
			nxt_q.conv_ctrl[`ACS_CC_START] = 1'b0;
			if (!q_ff.lock) begin
				nxt_q.res = adc_result_i;
			end
		end

		// other channels only while nothing amplified is running or pending
		nxt_q.grant = other_conv_req_i && !nxt_q.adc.busy &&
			!q_ff.conv_ctrl[`ACS_CC_START];

		// wishbone classic: one wait state, ack for one cycle
		bus_req = wb_cyc_i && wb_stb_i && !q_ff.ack;
		nxt_q.ack = bus_req;
		nxt_q.dat = `ACS_RST_BYTE;
		if (bus_req && !wb_we_i) begin
			case (wb_adr_i)
				`ACS_ADR_PIN_DIS: nxt_q.dat = q_ff.pin_dis;
				`ACS_ADR_AMP_CSR: nxt_q.dat = q_ff.amp_csr;
				`ACS_ADR_CONV_CTRL: nxt_q.dat = q_ff.conv_ctrl;
				`ACS_ADR_RES_LO: begin
					nxt_q.dat = q_ff.res[7:0];
					nxt_q.lock = 1'b1;
				end
				`ACS_ADR_RES_HI: begin
					nxt_q.dat = {6'h00, q_ff.res[9:8]};
					nxt_q.lock = 1'b0;
				end
				`ACS_ADR_STATUS: nxt_q.dat = {4'h0, q_ff.lock, q_ff.trig_pend,
					q_ff.amp_on, q_ff.adc.busy};
				default: nxt_q.dat = `ACS_RST_BYTE;
			endcase
		end
		if (bus_req && wb_we_i && wb_sel_i[0]) begin
			case (wb_adr_i)
				`ACS_ADR_PIN_DIS: nxt_q.pin_dis = wbyte;
				`ACS_ADR_AMP_CSR: nxt_q.amp_csr = wbyte & `ACS_CSR_WMASK;
				`ACS_ADR_CONV_CTRL: begin
					// start only sets; hardware clears it, a set in that cycle wins
					nxt_q.conv_ctrl = {wbyte[7:1],
						wbyte[`ACS_CC_START] | nxt_q.conv_ctrl[`ACS_CC_START]};
					if (!wbyte[`ACS_CC_AUTO]) begin
						nxt_q.trig_pend = 1'b0;
					end
				end
				default: nxt_q.ack = bus_req;
			endcase
		end

		// analog switch and gain drive
		nxt_q.ana.buf_en = ~nxt_q.pin_dis[`ACS_PIN_DIS_HI:0];
		nxt_q.ana.amp_enable = nxt_q.amp_on;
		nxt_q.ana.gain = gain_of(nxt_q.amp_csr[`ACS_CSR_G_HI:`ACS_CSR_G_LO]);
		nxt_q.ana.shunt = nxt_q.amp_csr[`ACS_CSR_IS];
		nxt_q.ana.ground_sw = nxt_q.amp_csr[`ACS_CSR_GS] & ~nxt_q.amp_csr[`ACS_CSR_IS];
		nxt_q.ana.neg_pin_connect = ~nxt_q.amp_csr[`ACS_CSR_GS];
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_ff <= '0;
			q_ff.ana.buf_en <= 3'h7;
			q_ff.ana.neg_pin_connect <= 1'b1;
			q_ff.ana.gain <= `ACS_GAIN_5;
		end else begin
			q_ff <= nxt_q;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign wb_dat_o = {24'h000000, q_ff.dat};
	assign wb_ack_o = q_ff.ack;
	assign pin_value_o = q_ff.pin_o;
	assign analog_o = q_ff.ana;
	assign amp_sample_o = q_ff.sample;
	assign divided_sync_clock_o = q_ff.div_clk;
	assign adc_o = q_ff.adc;
	assign other_conv_grant_o = q_ff.grant;

endmodule // acs_sync_ctrl

// ### rtl/acs_consts.svh
/*
 * constants of the amplified channel sync and control block: register byte addresses,
 * field positions, reset values and timing counts.
 * assumes a 250 MHz adc clock and a 32-bit classic wishbone bus with byte addresses.
 */
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define ACS_ADR_PIN_DIS 6'h00
`define ACS_ADR_AMP_CSR 6'h04
`define ACS_ADR_CONV_CTRL 6'h08
`define ACS_ADR_RES_LO 6'h0C
`define ACS_ADR_RES_HI 6'h10
`define ACS_ADR_STATUS 6'h14

// ****************************************
// field positions
// ****************************************
`define ACS_CSR_EN 7
`define ACS_CSR_IS 6
`define ACS_CSR_G_HI 5
`define ACS_CSR_G_LO 4
`define ACS_CSR_GS 3
`define ACS_CSR_TS_HI 1
`define ACS_CSR_TS_LO 0
`define ACS_CSR_WMASK 8'hFB
`define ACS_CC_START 0
`define ACS_CC_AUTO 1
`define ACS_CC_TS_HI 7
`define ACS_CC_TS_LO 4
`define ACS_PIN_DIS_HI 2

// ****************************************
// reset values and counts
// ****************************************
`define ACS_RST_BYTE 8'h00
`define ACS_DIV_LAST 3'h7
`define ACS_CONV_LOW 4'hD
`define ACS_CONV_HIGH 4'hE
`define ACS_SAMPLE_CYC 4'h2
`define ACS_GAIN_5 6'h05
`define ACS_GAIN_10 6'h0A
`define ACS_GAIN_20 6'h14
`define ACS_GAIN_40 6'h28

`endif

// ### rtl/acs_pkg.sv
/*
 * types of the amplified channel sync and control block.
 * assumes acs_consts.svh is on the include path.
 */
package acs_pkg;

	typedef enum logic [1:0] {
		ACS_SYNC_INTERNAL,
		ACS_SYNC_PWM_R,
		ACS_SYNC_NONE,
		ACS_SYNC_PWM_2
	} acs_sync_src_t;

	typedef struct packed {
		logic [2:0] buf_en;
		logic amp_enable;
		logic [5:0] gain;
		logic shunt;
		logic ground_sw;
		logic neg_pin_connect;
	} acs_analog_ctl_t;

	typedef struct packed {
		logic start;
		logic abort;
		logic busy;
	} acs_adc_ctl_t;

	typedef struct packed {
		logic [7:0] pin_dis;
		logic [7:0] amp_csr;
		logic [7:0] conv_ctrl;
		logic [2:0] div_cnt;
		logic div_clk;
		logic [2:0] pin_m;
		logic [2:0] pin_s;
		logic [2:0] pin_o;
		logic [1:0] evt_m;
		logic [1:0] evt_s;
		logic [1:0] evt_d;
		logic chg_m;
		logic chg_s;
		logic amp_on;
		logic sample;
		logic trig_pend;
		logic restart_wait;
		logic [3:0] cnt;
		logic [3:0] len;
		logic [9:0] res;
		logic lock;
		logic grant;
		logic ack;
		logic [7:0] dat;
		acs_analog_ctl_t ana;
		acs_adc_ctl_t adc;
	} acs_state_t;

endpackage

// ### bench/acs_sync_ctrl_assertions.sv
/* port checker of acs_sync_ctrl.
   assumes it is bound into every instance of the block. */
`timescale 1ns/1ps
module acs_chk
	import acs_pkg::*;
(
	// watched ports
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [2:0] pin_value_o,
	input wire logic amp_sample_o,
	input wire logic divided_sync_clock_o,
	input wire logic other_conv_grant_o,
	input wire acs_analog_ctl_t analog_o,
	input wire acs_adc_ctl_t adc_o
);
	// ********
	// properties
	// ********
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	pin_off_a: assert property ((pin_value_o & ~analog_o.buf_en & ~$past(analog_o.buf_en)) == 3'h0)
		else $error("disabled pin reads high");
	div_wave_a: assert property ($rose(divided_sync_clock_o) |=> divided_sync_clock_o[*3]
		##1 !divided_sync_clock_o[*4] ##1 divided_sync_clock_o) else $error("divided clock shape");
	// an abort restarts the count, so it drops the attempt
	conv_len_a: assert property (disable iff (rst_i || adc_o.abort)
		adc_o.start |-> ##12 adc_o.busy ##[1:2] !adc_o.busy) else $error("conversion length");
	grant_busy_a: assert property (adc_o.busy |-> !other_conv_grant_o)
		else $error("grant while busy");
	gnd_pin_a: assert property (analog_o.ground_sw |-> !analog_o.neg_pin_connect)
		else $error("pin joined while grounded");
	shunt_gnd_a: assert property (analog_o.shunt |-> !analog_o.ground_sw)
		else $error("ground held in shunt");
	samp_en_a: assert property (amp_sample_o |-> analog_o.amp_enable || $past(analog_o.amp_enable))
		else $error("sample while off");
	off_defer_a: assert property (adc_o.busy && $past(adc_o.busy) |-> !$fell(analog_o.amp_enable))
		else $error("disabled mid conversion");
	cover property (adc_o.start);
	cover property (adc_o.abort);
	cover property (amp_sample_o);
endmodule // acs_chk

bind acs_sync_ctrl acs_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .pin_value_o(pin_value_o),
	.amp_sample_o(amp_sample_o), .divided_sync_clock_o(divided_sync_clock_o),
	.other_conv_grant_o(other_conv_grant_o), .analog_o(analog_o), .adc_o(adc_o));

// ### bench/acs_far_model.sv
/* far side model: pwm sync events, adc core code, amplifier change flag.
   assumes the block's clock and its adc_o outputs. */
`timescale 1ns/1ps
module acs_far_model
	import acs_pkg::*;
(
	// clock and block side
	input wire logic clk_i,
	input wire logic rst_i,
	input wire acs_adc_ctl_t adc_o,
	input wire logic chg_cmd_i,
	// far side drive
	output logic pwm_r_o,
	output logic pwm_2_o,
	output logic amp_change_o,
	output logic [9:0] code_o
);
	logic [3:0] ph_ff;
	logic n_ff;
	logic busy_ff;
	// one event per 16 clocks, well under a quarter of the clock
	assign pwm_r_o = ph_ff[3];
	assign pwm_2_o = ~ph_ff[3];
	// code alternates per completion so stale results show
	assign code_o = n_ff ? 10'h2AA : 10'h155;
	assign amp_change_o = chg_cmd_i;
	always_ff @(posedge clk_i) begin
		ph_ff <= rst_i ? 4'h0 : ph_ff + 4'h1;
		busy_ff <= adc_o.busy;
		n_ff <= rst_i ? 1'b0 : n_ff ^ (busy_ff & ~adc_o.busy);
	end
endmodule // acs_far_model

// ### bench/tb_top.sv
/* self-checking bench of the amplified channel block.
   assumes acs_far_model on the far side and acs_chk bound in. */
`timescale 1ns/1ps
module tb_top
	import acs_pkg::*;
;
	typedef struct packed {logic [7:0] csr; logic [5:0] gain; logic [2:0] sw;} acs_row_t;
	acs_row_t rows [5] = '{'{8'h00, 6'h05, 3'h1}, '{8'h10, 6'h0A, 3'h1}, '{8'h24, 6'h14, 3'h1},
		'{8'h38, 6'h28, 3'h2}, '{8'h48, 6'h05, 3'h4}};
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, chg = 1'b0, req = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [31:0] wdat = 32'h0, rdat, rdo;
	logic [2:0] pins = 3'h7, pv;
	logic [15:0] trig = 16'h0;
	logic [9:0] code;
	logic ack, samp, dclk, grant, pr, p2, amp_chg;
	acs_analog_ctl_t ana;
	acs_adc_ctl_t adc;
	int fails = 0, checks_done = 0, cyc_n = 0, samps = 0, starts = 0, aborts = 0, n0, len;
	int dhi = 0, d0;
	acs_sync_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack),
		.pin_level_i(pins), .pin_value_o(pv), .pwm_ctrl_r_sync_event_i(pr),
		.pwm_ctrl_2_sync_event_i(p2), .auto_trig_evt_i(trig), .amp_out_change_i(amp_chg),
		.analog_o(ana), .amp_sample_o(samp), .divided_sync_clock_o(dclk), .adc_result_i(code),
		.adc_o(adc), .other_conv_req_i(req), .other_conv_grant_o(grant));
	acs_far_model far (.clk_i(clk_i), .rst_i(rst_i), .adc_o(adc), .chg_cmd_i(chg),
		.pwm_r_o(pr), .pwm_2_o(p2), .amp_change_o(amp_chg), .code_o(code));
	initial forever #2 clk_i = ~clk_i;
	// ********
	// tasks
	// ********
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		rdat = rdo;
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic done;
		while (adc.busy !== 1'b0) @(posedge clk_i);
	endtask
	// counters read off the negative edge, where outputs are settled
	always @(negedge clk_i) begin
		cyc_n++;
		samps += samp;
		dhi += dclk;
		starts += adc.start;
		aborts += adc.abort;
		if (cyc_n == 5000) begin
			fails++;
			summarize();
		end
	end
	// ********
	// sequence
	// ********
	initial begin
		tick(20);
		rst_i <= 1'b0;
		tick(4);
		chk({ana, pv}, {13'h1C29, 3'h7});
		bus(0, 6'h3C, 8'h00);
		chk(rdat, 0);
		foreach (rows[i]) begin
			bus(1, 6'h04, rows[i].csr);
			bus(0, 6'h04, 8'h00);
			chk(rdat, rows[i].csr & 8'hFB);
			chk({ana.gain, ana.shunt, ana.ground_sw, ana.neg_pin_connect},
				{rows[i].gain, rows[i].sw});
		end
		bus(1, 6'h00, 8'h05);
		tick(4);
		chk(pv, 3'h2);
		chk(ana.buf_en, 3'h2);
		for (int s = 0; s < 4; s++) begin
			bus(1, 6'h04, 8'h80 | s[7:0]);
			tick(8);
			n0 = samps;
			d0 = dhi;
			tick(64);
			chk(samps - n0, s == 0 ? 8 : s == 2 ? 0 : 4);
			chk(dhi - d0, 32);
		end
		bus(1, 6'h04, 8'h80);
		tick(32);
		req <= 1'b1;
		bus(1, 6'h08, 8'h01);
		chk({adc.busy, grant}, 2'b10);
		for (len = 0; adc.busy === 1'b1; len++) @(posedge clk_i);
		tick(2);
		chk({len == 13 || len == 14, grant}, 2'b11);
		bus(0, 6'h0C, 8'h00);
		chk(rdat, 8'h55);
		bus(0, 6'h10, 8'h00);
		chk(rdat, 8'h01);
		n0 = starts;
		tick(40);
		bus(0, 6'h08, 8'h00);
		chk({starts - n0, rdat[0]}, 0);
		bus(0, 6'h0C, 8'h00);
		bus(1, 6'h08, 8'h01);
		bus(1, 6'h04, 8'h00);
		chk(ana.amp_enable, 1'b1);
		done();
		tick(2);
		chk(ana.amp_enable, 1'b0);
		bus(0, 6'h10, 8'h00);
		chk(rdat, 8'h01);
		bus(1, 6'h04, 8'h80);
		tick(32);
		chg <= 1'b1;
		n0 = starts;
		len = aborts;
		bus(1, 6'h08, 8'h01);
		tick(20);
		chg <= 1'b0;
		tick(30);
		done();
		chk({aborts - len, starts - n0}, {32'd1, 32'd2});
		bus(1, 6'h08, 8'h33);
		n0 = starts;
		tick(30);
		chk(starts - n0, 0);
		trig <= 16'h0008;
		tick(1);
		trig <= 16'h0000;
		tick(16);
		chk(starts - n0, 1);
		summarize();
	end
endmodule // tb_top
